/* File: hdl/anr_defs.vh */
// Constants of the auto-negotiation ability and status register bank.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef ANR_DEFS_VH
`define ANR_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define ANR_IDX_ADVERT     4'h4
`define ANR_IDX_PARTNER    4'h5
`define ANR_IDX_EXPANSION  4'h6
`define ANR_ADDR_ADVERT    8'h10
`define ANR_ADDR_PARTNER   8'h14
`define ANR_ADDR_EXPANSION 8'h18
`define ANR_ADDR_OPTION    8'h40
`define ANR_ADDR_IRQ_STAT  8'h44
`define ANR_ADDR_IRQ_MASK  8'h48

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ANR_ADV_FD10_BIT   6
`define ANR_ADV_HD10_BIT   5
`define ANR_EXP_BASE_BIT   5
`define ANR_EXP_PDF_BIT    4
`define ANR_EXP_LPNP_BIT   3
`define ANR_EXP_NPA_BIT    2
`define ANR_EXP_PRX_BIT    1
`define ANR_EXP_LPAN_BIT   0
`define ANR_OPT_ALTNP_BIT  1

// ----------------------------------------------------------------------------
// Selector codes and reset values
// ----------------------------------------------------------------------------
`define ANR_SEL_8023       5'h01
`define ANR_SEL_8029       5'h02
`define ANR_SEL_RSVD_LO    5'h00
`define ANR_SEL_RSVD_HI    5'h1F
`define ANR_SEL_RST        5'h01
`define ANR_PARTNER_RST    16'h0000
`define ANR_OPT_RST        16'h0000
`define ANR_IRQ_RST        3'h0

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define ANR_STRAP_WAIT     3'h2

`endif

/* File: hdl/anr_latch_flag.v */
// Latching-high flag: set wins over clear, cleared after a read saw it.
// Assumes rd_seen pulses at the APB read completion of its register.
`timescale 1ns/1ps
module anr_latch_flag (
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire set_ev,
  input  wire rd_seen,
  input  wire force_clr,
  output reg  flag_q
);
  // Clear only a 1 that the read returned; a new set wins
  always @(posedge ref_clk) begin
    if (sys_rst)
      flag_q <= 1'b0;
    else if (set_ev)
      flag_q <= 1'b1;
    else if ((rd_seen && flag_q) || force_clr)
      flag_q <= 1'b0;
  end
endmodule // anr_latch_flag

/* File: hdl/anr_regs.v */
// Auto-negotiation advertisement, partner base page and expansion registers.
// Assumes APB on ref_clk; negotiation events are pulses on ref_clk; straps
// and partner page bits come from outside and are synchronised here.
// Latched flags clear on a read that returned them as 1; page received also clears on the option's forced clear.
`timescale 1ns/1ps
`include "anr_defs.vh"
module anr_regs (
  input  wire        ref_clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Hardware configuration straps (pins)
  input  wire        strap_fd10,
  input  wire        strap_hd10,
  // Received partner base page word (pins, held while stable)
  input  wire [15:0] partner_word,
  input  wire        partner_an_able,
  input  wire        partner_np_able,
  // Negotiation events, one-cycle pulses on ref_clk; page_is_base, mr_page_rx and transmit_disable are levels
  input  wire        base_page_ev,
  input  wire        page_rx_ev,
  input  wire        page_is_base,
  input  wire        pd_fault_ev,
  input  wire        mr_page_rx,
  input  wire        transmit_disable,
  // Local advertisement and option towards the negotiation logic, and the interrupt
  output reg  [15:0] advert_word,
  output reg         alt_next_page_option,
  output reg         irq
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  wire [15:0] pw_s;
  wire        fd10_s;
  wire        hd10_s;
  wire        lpan_s;
  wire        lpnp_s;

  // Partner word, one synchroniser per bit
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pw
      anr_sync2 u_s (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .d_in    (partner_word[gi]),
        .d_out   (pw_s[gi])
      );
    end
  endgenerate

  // Straps and partner ability levels
  anr_sync2 u_fd (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d_in    (strap_fd10),
    .d_out   (fd10_s)
  );

  anr_sync2 u_hd (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d_in    (strap_hd10),
    .d_out   (hd10_s)
  );

  anr_sync2 u_an (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d_in    (partner_an_able),
    .d_out   (lpan_s)
  );

  anr_sync2 u_np (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d_in    (partner_np_able),
    .d_out   (lpnp_s)
  );

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  // Transfer completes at the edge where pready is seen high
  wire wr_en = psel & penable & pwrite & pready;
  wire rd_en = psel & penable & ~pwrite & pready;
  // Register hits by byte address
  wire hit_adv  = (paddr == `ANR_ADDR_ADVERT);
  wire hit_par  = (paddr == `ANR_ADDR_PARTNER);
  wire hit_exp  = (paddr == `ANR_ADDR_EXPANSION);
  wire hit_opt  = (paddr == `ANR_ADDR_OPTION);
  wire hit_ist  = (paddr == `ANR_ADDR_IRQ_STAT);
  wire hit_imk  = (paddr == `ANR_ADDR_IRQ_MASK);
  wire hit_any  = hit_adv | hit_par | hit_exp | hit_opt | hit_ist | hit_imk;

  // --------------------------------------------------------------------------
  // Strap capture after reset release
  // --------------------------------------------------------------------------
  reg [2:0] strap_cnt_q;
  reg       strap_done_q;

  // Wait for the synchronisers to fill, then load defaults once
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      strap_cnt_q  <= 3'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 3'h1;
      if (strap_cnt_q == `ANR_STRAP_WAIT)
        strap_done_q <= 1'b1;
    end
  end

  // One-cycle load pulse once the synchronisers hold the straps
  wire strap_load = !strap_done_q && (strap_cnt_q == `ANR_STRAP_WAIT);

  // --------------------------------------------------------------------------
  // Local advertisement register (lower bits held here)
  // --------------------------------------------------------------------------
  reg       fd10_q;
  reg       hd10_q;
  reg [4:0] sel_q;
  wire [4:0] sel_wr = pwdata[4:0];
  wire sel_ok = (sel_wr == `ANR_SEL_8023) || (sel_wr == `ANR_SEL_8029);

  // Abilities from straps; selector accepts only defined codes
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      fd10_q <= 1'b0;
      hd10_q <= 1'b0;
      sel_q  <= `ANR_SEL_RST;
    end else if (strap_load) begin
      fd10_q <= fd10_s;
      hd10_q <= hd10_s;
    end else if (wr_en && hit_adv) begin
      fd10_q <= pwdata[`ANR_ADV_FD10_BIT];
      hd10_q <= pwdata[`ANR_ADV_HD10_BIT];
      if (sel_ok)
        sel_q <= sel_wr;
    end
  end

  wire [15:0] adv_rd = {9'h000, fd10_q, hd10_q, sel_q};

  // --------------------------------------------------------------------------
  // Partner base page register
  // --------------------------------------------------------------------------
  reg [15:0] partner_q;

  // Loaded when a base page is received; bit 12 forced to zero
  always @(posedge ref_clk) begin
    if (sys_rst)
      partner_q <= `ANR_PARTNER_RST;
    else if (page_rx_ev && page_is_base)
      partner_q <= {pw_s[15:13], 1'b0, pw_s[11:0]};
  end

  // --------------------------------------------------------------------------
  // Option register
  // --------------------------------------------------------------------------
  // Written by software, read back at bit 1
  always @(posedge ref_clk) begin
    if (sys_rst)
      alt_next_page_option <= 1'b0;
    else if (wr_en && hit_opt)
      alt_next_page_option <= pwdata[`ANR_OPT_ALTNP_BIT];
  end

  // --------------------------------------------------------------------------
  // Expansion register latched flags
  // --------------------------------------------------------------------------
  // Read completion of the expansion register
  wire exp_rd = rd_en && hit_exp;
  wire base_q;
  wire pdf_q;
  wire prx_q;
  wire prx_force = alt_next_page_option && (!mr_page_rx || transmit_disable);

  // Flags the completing read returned; prdata still holds that word
  wire base_rd = exp_rd && prdata[`ANR_EXP_BASE_BIT];
  wire pdf_rd  = exp_rd && prdata[`ANR_EXP_PDF_BIT];
  wire prx_rd  = exp_rd && prdata[`ANR_EXP_PRX_BIT];

  // Base page flag; reads back only with the option set
  anr_latch_flag u_base (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .set_ev    (base_page_ev),
    .rd_seen   (base_rd),
    .force_clr (1'b0),
    .flag_q    (base_q)
  );

  // Parallel detection fault flag
  anr_latch_flag u_pdf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .set_ev    (pd_fault_ev),
    .rd_seen   (pdf_rd),
    .force_clr (1'b0),
    .flag_q    (pdf_q)
  );

  // Page received flag; the option adds a forced clear
  anr_latch_flag u_prx (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .set_ev    (page_rx_ev),
    .rd_seen   (prx_rd),
    .force_clr (prx_force),
    .flag_q    (prx_q)
  );

  reg lpnp_q;
  reg lpan_q;

  // Partner next-page and auto-negotiation ability levels
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      lpnp_q <= 1'b0;
      lpan_q <= 1'b0;
    end else begin
      lpnp_q <= lpnp_s;
      lpan_q <= lpan_s;
    end
  end

  // Upper bits reserved, local next page able fixed at 1
  wire [15:0] exp_rd_word = {10'h000,
                             base_q & alt_next_page_option,
                             pdf_q, lpnp_q,
                             1'b1,
                             prx_q, lpan_q};

  // --------------------------------------------------------------------------
  // Interrupts: sticky on negotiation event pulses, write one to clear
  // --------------------------------------------------------------------------
  reg  [2:0] ist_q;
  reg  [2:0] imk_q;
  wire [2:0] ev_vec  = {base_page_ev, pd_fault_ev, page_rx_ev};
  wire [2:0] ist_clr = (wr_en && hit_ist) ? pwdata[2:0] : 3'h0;

  // Sticky status; an event in the clearing cycle wins
  always @(posedge ref_clk) begin
    if (sys_rst)
      ist_q <= `ANR_IRQ_RST;
    else
      ist_q <= ev_vec | (ist_q & ~ist_clr);
  end

  // Mask, same layout as the status
  always @(posedge ref_clk) begin
    if (sys_rst)
      imk_q <= `ANR_IRQ_RST;
    else if (wr_en && hit_imk)
      imk_q <= pwdata[2:0];
  end

  // Level interrupt, one cycle behind the status
  always @(posedge ref_clk) begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(ist_q & imk_q);
  end

  // --------------------------------------------------------------------------
  // APB answer: one wait state, read data registered
  // --------------------------------------------------------------------------
  reg [15:0] rd_mux;

  // Read word of the addressed register
  always @* begin
    rd_mux = 16'h0000;
    if (hit_adv)
      rd_mux = adv_rd;
    else if (hit_par)
      rd_mux = partner_q;
    else if (hit_exp)
      rd_mux = exp_rd_word;
    else if (hit_opt)
      rd_mux = {14'h0000, alt_next_page_option, 1'b0};
    else if (hit_ist)
      rd_mux = {13'h0000, ist_q};
    else if (hit_imk)
      rd_mux = {13'h0000, imk_q};
  end

  // pready one cycle after the access phase starts
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_mux};
      pslverr <= !hit_any;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Advertisement word towards the link side
  // --------------------------------------------------------------------------
  // Selector as sent: a reserved code never leaves the block
  wire       sel_tx_ok = (sel_q == `ANR_SEL_8023) || (sel_q == `ANR_SEL_8029);
  wire [4:0] sel_tx    = sel_tx_ok ? sel_q : `ANR_SEL_RST;

  // Registered copy for the negotiation logic
  always @(posedge ref_clk) begin
    if (sys_rst)
      advert_word <= {11'h000, `ANR_SEL_RST};
    else
      advert_word <= {adv_rd[15:5], sel_tx};
  end

endmodule // anr_regs

/* File: hdl/anr_sync2.v */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level is quasi-static compared with ref_clk.
`timescale 1ns/1ps
module anr_sync2 (
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire d_in,
  output reg  d_out
);
  reg meta_q;

  // Second stage alone reads the first
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      d_out  <= 1'b0;
    end else begin
      meta_q <= d_in;
      d_out  <= meta_q;
    end
  end
endmodule // anr_sync2

/* File: tb/anr_chk.sv */
// Checker for the bank's APB answers and advertisement output.
// Assumes a bind to anr_regs; one clock domain.
`timescale 1ns/1ps
`include "anr_defs.vh"
module anr_chk (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] advert_word,
  input wire logic        irq
);
  logic        wr_adv;
  logic        rd_ok;
  logic        sel_ok;
  logic [15:0] wd_q;
  logic [4:0]  sel_q;
  // Completed transfers
  assign wr_adv = pready && psel && pwrite && paddr == `ANR_ADDR_ADVERT;
  assign rd_ok  = pready && psel && !pwrite;
  assign sel_ok = pwdata[4:0] == `ANR_SEL_8023 || pwdata[4:0] == `ANR_SEL_8029;
  // Write data and old selector
  always @(posedge ref_clk) begin
    if (wr_adv) begin
      wd_q  <= pwdata[15:0];
      sel_q <= advert_word[4:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  rdy_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_rdy_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  exp_zero_a: assert property (
    rd_ok && paddr == `ANR_ADDR_EXPANSION |-> prdata[15:6] == 10'h000)
    else $error("expansion reserved bits set");
  np_able_a: assert property (
    rd_ok && paddr == `ANR_ADDR_EXPANSION |-> prdata[2])
    else $error("next page able bit low");
  base_rsvd_a: assert property (
    rd_ok && paddr == `ANR_ADDR_PARTNER |-> !prdata[12])
    else $error("partner reserved bit set");
  sel_legal_a: assert property (
    advert_word[4:0] == `ANR_SEL_8023 || advert_word[4:0] == `ANR_SEL_8029)
    else $error("selector illegal");
  adv_wr_a: assert property (
    wr_adv |-> ##2 advert_word[6:5] == wd_q[6:5])
    else $error("ability bits not written");
  sel_wr_a: assert property (
    wr_adv && sel_ok |-> ##2 advert_word[4:0] == wd_q[4:0])
    else $error("selector not written");
  sel_keep_a: assert property (
    wr_adv && !sel_ok |-> ##2 advert_word[4:0] == sel_q)
    else $error("reserved selector taken");
  cover property (wr_adv);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule // anr_chk

bind anr_regs anr_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .advert_word(advert_word), .irq(irq));

/* File: tb/anr_partner.sv */
// Link partner model: received base page image and negotiation events.
// Assumes tasks are called by the bench right after a clock edge.
`timescale 1ns/1ps
module anr_partner (
  input  wire logic        ref_clk,
  output logic [15:0] partner_word,
  output logic        partner_an_able,
  output logic        partner_np_able,
  output logic        base_page_ev,
  output logic        page_rx_ev,
  output logic        page_is_base,
  output logic        pd_fault_ev
);
  // Idle partner at time zero
  initial begin
    {partner_word, partner_an_able, partner_np_able} = 18'h0;
    {base_page_ev, page_rx_ev, page_is_base, pd_fault_ev} = 4'h0;
  end
  // Base page: word settles before the received pulse
  task send_page(input logic [15:0] w);
    @(posedge ref_clk);
    partner_word <= {w[15:5], (w[4:0] == 5'h00 || w[4:0] == 5'h1F) ? 5'h01 : w[4:0]};
    {partner_an_able, partner_np_able, page_is_base} <= 3'h7;
    repeat (4) @(posedge ref_clk);
    page_rx_ev <= 1'b1;
    @(posedge ref_clk);
    page_rx_ev <= 1'b0;
  endtask
  // One-cycle event pulses
  task pulse(input logic f);
    @(posedge ref_clk);
    {base_page_ev, pd_fault_ev} <= {!f, f};
    @(posedge ref_clk);
    {base_page_ev, pd_fault_ev} <= 2'h0;
  endtask
endmodule // anr_partner

/* File: tb/tb_top.sv */
// Bench for anr_regs: APB master, straps and partner model.
// Assumes the design and anr_defs.vh on the include path.
`timescale 1ns/1ps
`include "anr_defs.vh"
module tb_top;
  logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err_q;
  logic        strap_fd10, strap_hd10, mr_page_rx, transmit_disable, alt_np, irq;
  logic        an_able, np_able, base_ev, rx_ev, is_base, pdf_ev;
  logic [7:0]  paddr;
  logic [15:0] pword, advert_word;
  logic [31:0] pwdata, prdata, rd_q;
  int          bad_count, check_count;
  anr_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_fd10(strap_fd10), .strap_hd10(strap_hd10),
    .partner_word(pword), .partner_an_able(an_able), .partner_np_able(np_able),
    .base_page_ev(base_ev), .page_rx_ev(rx_ev), .page_is_base(is_base),
    .pd_fault_ev(pdf_ev), .mr_page_rx(mr_page_rx), .transmit_disable(transmit_disable),
    .advert_word(advert_word), .alt_next_page_option(alt_np), .irq(irq));
  anr_partner u_lp (.ref_clk(ref_clk), .partner_word(pword), .partner_an_able(an_able),
    .partner_np_able(np_able), .base_page_ev(base_ev), .page_rx_ev(rx_ev),
    .page_is_base(is_base), .pd_fault_ev(pdf_ev));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer, bounded wait for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd_q = prdata;
    err_q = pslverr;
    {psel, penable} <= 2'h0;
    if (n >= 16) begin
      chk("pready", 32'h1, 32'h0);
      results;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd_q);
  endtask
  task t_reset;
    rd(`ANR_ADDR_ADVERT, 32'h41, "advert");
    chk("advert_word", 32'h41, {16'h0, advert_word});
    rd(`ANR_ADDR_PARTNER, 32'h0, "partner");
    rd(`ANR_ADDR_EXPANSION, 32'h4, "expansion");
    $display("test reset done");
  endtask
  task t_advert;
    apb(1'b1, `ANR_ADDR_ADVERT, 32'h22);
    rd(`ANR_ADDR_ADVERT, 32'h22, "advert");
    apb(1'b1, `ANR_ADDR_ADVERT, 32'h5F);
    rd(`ANR_ADDR_ADVERT, 32'h42, "advert");
    apb(1'b1, `ANR_ADDR_ADVERT, 32'h20);
    rd(`ANR_ADDR_ADVERT, 32'h22, "advert");
    $display("test advert done");
  endtask
  task t_page;
    apb(1'b1, `ANR_ADDR_IRQ_MASK, 32'h1);
    u_lp.send_page(16'hFFE1);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`ANR_ADDR_PARTNER, 32'hEFE1, "partner");
    rd(`ANR_ADDR_EXPANSION, 32'hF, "expansion");
    rd(`ANR_ADDR_EXPANSION, 32'hD, "expansion");
    apb(1'b1, `ANR_ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test page done");
  endtask
  task t_fault;
    u_lp.pulse(1'b1);
    repeat (6) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(`ANR_ADDR_EXPANSION, 32'h1D, "expansion");
    rd(`ANR_ADDR_EXPANSION, 32'hD, "expansion");
    $display("test fault done");
  endtask
  task t_altnp;
    apb(1'b1, `ANR_ADDR_OPTION, 32'h2);
    transmit_disable <= 1'b1;
    u_lp.pulse(1'b0);
    chk("alt_np", 32'h1, {31'h0, alt_np});
    u_lp.send_page(16'h4021);
    repeat (3) @(posedge ref_clk);
    rd(`ANR_ADDR_PARTNER, 32'h4021, "partner");
    rd(`ANR_ADDR_EXPANSION, 32'h2D, "expansion");
    rd(`ANR_ADDR_EXPANSION, 32'hD, "expansion");
    transmit_disable <= 1'b0;
    $display("test altnp done");
  endtask
  task t_bad;
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err_q});
    chk("rdata", 32'h0, rd_q);
    apb(1'b1, `ANR_ADDR_PARTNER, 32'hFFFF);
    rd(`ANR_ADDR_PARTNER, 32'h4021, "partner");
    apb(1'b1, `ANR_ADDR_EXPANSION, 32'hFFFF);
    rd(`ANR_ADDR_EXPANSION, 32'hD, "expansion");
    $display("test bad done");
  endtask
  // Main sequence
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {strap_fd10, strap_hd10, mr_page_rx, transmit_disable} = 4'hA;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset;
    t_advert;
    t_page;
    t_fault;
    t_altnp;
    t_bad;
    results;
  end
endmodule // tb_top
